// ==== src/fwp_consts.svh ====
// Purpose: constants of the flash write protection and unlock logic
// Assumes: 8-bit register port, 100 MHz clock
// Notes:   offsets are word indices on the plain register port
`ifndef FWP_CONSTS_SVH
`define FWP_CONSTS_SVH
`define FWP_ADDR_W        2
`define FWP_DATA_W        8
`define FWP_ADR_CTRL      2'h0
`define FWP_ADR_SHARED    2'h1
`define FWP_ADR_STATUS    2'h2
`define FWP_KEY1          8'h73
`define FWP_KEY2          8'h8c
`define FWP_CMD_ERASE     8'h95
`define FWP_CMD_SECTSEL   8'h5e
`define FWP_PAGE_W        4
`define FWP_OFFS_W        9
`define FWP_SECTORS       8
`define FWP_PROT_RESET    8'h00
`define FWP_ST_UNLOCKED   0
`define FWP_ST_ACTIVE     1
`define FWP_ST_SECTSEL    2
`define FWP_ST_PROGGED    3
`define FWP_ST_OPTION     4
`endif

// ==== src/fwp_pkg.sv ====
// Purpose: types of the flash write protection and unlock logic
// Assumes: constants come from fwp_consts.svh
// Notes:   command carrier travels to the flash array
`include "fwp_consts.svh"
package fwp_pkg;
  typedef enum logic [2:0] {
    FWP_LOCKED  = 3'b000,
    FWP_PAGE1   = 3'b001,
    FWP_KEY1_OK = 3'b010,
    FWP_KEY2_OK = 3'b011,
    FWP_OPEN    = 3'b100,
    FWP_PROG    = 3'b101
  } fwp_state_e;
  typedef struct packed {
    logic                   erase;
    logic                   mass;
    logic                   prog;
    logic [`FWP_PAGE_W-1:0] page;
    logic [`FWP_OFFS_W-1:0] offs;
    logic [7:0]             data;
  } fwp_cmd_s;
endpackage

// ==== src/fwp_lock.sv ====
// Purpose: lock, unlock key sequence and protection checks of the flash controller
// Assumes: single clock, synchronous active-high reset, user byte writes on a port
// Notes:   the array sees only pulses that passed every check
// Notes on behaviour
// - reset leaves the controller locked; nothing programs or page-erases until unlocked
// - second page write must match the first, else relock; match activates page
// - writing 95h with a page open and no byte yet written erases it unless its sector is protected
// - any control value while unlocked relocks, 95h included
// - mass erase comes only from the debug port
// - byte writes anywhere on the open page; page stays open afterwards
// - control write after byte programming started relocks
// - option bit 0 blocks user program, page and mass erase; debug mass erase stays
// - option bit 1 permits program and page erase, subject to other checks
// - eight sectors, each an eighth of memory or at least one page
// - protected sector refuses program and erase; bits can only be set
// - sector protect bits clear on reset
// - sector protect and page select share one address, steered by control
`timescale 1ns/1ps
`include "fwp_consts.svh"
module fwp_lock
  import fwp_pkg::*;
#(
  parameter logic [7:0] SECT_SEL_CMD = `FWP_CMD_SECTSEL
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   ce,
  input  wire logic [`FWP_ADDR_W-1:0] reg_addr,
  input  wire logic [`FWP_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`FWP_DATA_W-1:0] reg_rdata,
  input  wire logic                   global_write_protect_option,
  input  wire logic                   dbg_mass_erase,
  input  wire logic                   user_wr,
  input  wire logic [`FWP_OFFS_W-1:0] user_offs,
  input  wire logic [7:0]             user_data,
  output fwp_cmd_s                    flash_cmd
);

  fwp_state_e             state;
  fwp_state_e             next_state;
  logic [`FWP_PAGE_W-1:0] first_page;
  logic [`FWP_PAGE_W-1:0] active_page;
  logic [7:0]             sect_prot;
  logic                   sect_sel;

  // page to sector: with 16 pages in 8 sectors, two pages share a sector
  function automatic logic [2:0] sector_of(input logic [`FWP_PAGE_W-1:0] pg);
    sector_of = pg[`FWP_PAGE_W-1:1];
  endfunction

  logic ctrl_wr;
  logic shared_wr;
  logic page_ok;
  logic do_erase;
  logic do_prog;
  logic do_mass;
  assign ctrl_wr   = ce && reg_wr && reg_addr == `FWP_ADR_CTRL;
  assign shared_wr = ce && reg_wr && reg_addr == `FWP_ADR_SHARED;
  // option bit and sector protect gate both program and erase
  assign page_ok   = global_write_protect_option
                     && !sect_prot[sector_of(active_page)];
  assign do_erase  = ctrl_wr && state == FWP_OPEN
                     && reg_wdata == `FWP_CMD_ERASE && page_ok;
  // the control write wins over a byte write in the same cycle
  assign do_prog   = ce && user_wr && !ctrl_wr && page_ok
                     && (state == FWP_OPEN || state == FWP_PROG);
  // user code has no mass erase path at all; the debug port ignores the option bit
  assign do_mass   = ce && dbg_mass_erase;

  // unlock sequencer
  always_comb begin
    next_state = state;
    if (ctrl_wr) begin
      case (state)
        FWP_PAGE1:   next_state = reg_wdata == `FWP_KEY1 ? FWP_KEY1_OK : FWP_LOCKED;
        FWP_KEY1_OK: next_state = reg_wdata == `FWP_KEY2 ? FWP_KEY2_OK : FWP_LOCKED;
        default:     next_state = FWP_LOCKED;
      endcase
    end else if (shared_wr && !sect_sel) begin
      case (state)
        FWP_KEY2_OK: next_state = reg_wdata[`FWP_PAGE_W-1:0] == first_page
                                  ? FWP_OPEN : FWP_LOCKED;
        FWP_LOCKED:  next_state = FWP_PAGE1;
        FWP_PAGE1:   next_state = FWP_PAGE1;
        default:     next_state = FWP_LOCKED;
      endcase
    end else if (do_prog) begin
      next_state = FWP_PROG;
    end
  end

  // sequencer state, locked from reset
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= FWP_LOCKED;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // first and active page latches
  always_ff @(posedge clk) begin
    if (reset) begin
      first_page  <= '0;
      active_page <= '0;
    end else if (shared_wr && !sect_sel) begin
      if (state == FWP_LOCKED || state == FWP_PAGE1) begin
        first_page <= reg_wdata[`FWP_PAGE_W-1:0];
      end
      if (state == FWP_KEY2_OK) begin
        active_page <= reg_wdata[`FWP_PAGE_W-1:0];
      end
    end
  end

  // shared address steering: every control write reselects
  always_ff @(posedge clk) begin
    if (reset) begin
      sect_sel <= 1'b0;
    end else if (ctrl_wr) begin
      sect_sel <= reg_wdata == SECT_SEL_CMD;
    end
  end

  // sector protect only accumulates; reset is the only clear
  always_ff @(posedge clk) begin
    if (reset) begin
      sect_prot <= `FWP_PROT_RESET;
    end else if (shared_wr && sect_sel) begin
      sect_prot <= sect_prot | reg_wdata;
    end
  end

  // command pulses to the array, registered so refused requests never reach it
  always_ff @(posedge clk) begin
    if (reset) begin
      flash_cmd <= '0;
    end else if (ce) begin
      flash_cmd.erase <= do_erase;
      flash_cmd.mass  <= do_mass;
      flash_cmd.prog  <= do_prog;
      flash_cmd.page  <= active_page;
      flash_cmd.offs  <= user_offs;
      flash_cmd.data  <= user_data;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          `FWP_ADR_CTRL:   reg_rdata <= {5'h00, state};
          `FWP_ADR_SHARED: reg_rdata <= sect_sel ? sect_prot : {4'h0, active_page};
          `FWP_ADR_STATUS: begin
            reg_rdata[`FWP_ST_UNLOCKED] <= state == FWP_OPEN || state == FWP_PROG;
            reg_rdata[`FWP_ST_ACTIVE]   <= state == FWP_PROG;
            reg_rdata[`FWP_ST_SECTSEL]  <= sect_sel;
            reg_rdata[`FWP_ST_PROGGED]  <= flash_cmd.prog;
            reg_rdata[`FWP_ST_OPTION]   <= global_write_protect_option;
          end
          default:         reg_rdata <= '0;
        endcase
      end
    end
  end

  // assertions
  property p_reset_locked;
    @(posedge clk) reset |=> state == FWP_LOCKED;
  endproperty
  a_reset_locked: assert property (p_reset_locked) else $error("not locked after reset");

  // unlock steps: each key write moves one state, a wrong value drops back
  sequence s_first_key;
    ctrl_wr && state == FWP_PAGE1 && reg_wdata == `FWP_KEY1;
  endsequence
  sequence s_second_key;
    ctrl_wr && state == FWP_KEY1_OK && reg_wdata == `FWP_KEY2;
  endsequence
  sequence s_page_again;
    shared_wr && !sect_sel && state == FWP_KEY2_OK;
  endsequence
  property p_key_first;
    @(posedge clk) disable iff (reset) s_first_key |=> state == FWP_KEY1_OK;
  endproperty
  a_key_first: assert property (p_key_first) else $error("first key refused");

  property p_key_second;
    @(posedge clk) disable iff (reset) s_second_key |=> state == FWP_KEY2_OK;
  endproperty
  a_key_second: assert property (p_key_second) else $error("second key refused");

  property p_wrong_key;
    @(posedge clk) disable iff (reset)
      (ctrl_wr && state == FWP_PAGE1 && reg_wdata != `FWP_KEY1) |=> state == FWP_LOCKED;
  endproperty
  a_wrong_key: assert property (p_wrong_key) else $error("wrong key accepted");

  property p_page_match;
    @(posedge clk) disable iff (reset)
      s_page_again ##0 (reg_wdata[`FWP_PAGE_W-1:0] == first_page)
      |=> state == FWP_OPEN && active_page == $past(reg_wdata[`FWP_PAGE_W-1:0]);
  endproperty
  a_page_match: assert property (p_page_match) else $error("page not opened");

  // only a matching second page write opens a page
  property p_open_gate;
    @(posedge clk) disable iff (reset)
      (ce && state != FWP_OPEN && state != FWP_PROG && !(state == FWP_KEY2_OK && shared_wr))
      |=> state != FWP_OPEN && state != FWP_PROG;
  endproperty
  a_open_gate: assert property (p_open_gate) else $error("opened without keys");

  property p_prog_locked;
    @(posedge clk) disable iff (reset)
      (ce && state != FWP_OPEN && state != FWP_PROG) |=> !flash_cmd.prog;
  endproperty
  a_prog_locked: assert property (p_prog_locked) else $error("locked byte write");

  property p_no_erase_locked;
    @(posedge clk) disable iff (reset)
      (ce && state != FWP_OPEN) |=> !flash_cmd.erase;
  endproperty
  a_no_erase_locked: assert property (p_no_erase_locked) else $error("locked erase");

  property p_mismatch;
    @(posedge clk) disable iff (reset)
      (ce && state == FWP_KEY2_OK && shared_wr && !sect_sel && !ctrl_wr
       && reg_wdata[`FWP_PAGE_W-1:0] != first_page) |=> state == FWP_LOCKED;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatched page unlocked");

  property p_relock;
    @(posedge clk) disable iff (reset)
      (ctrl_wr && (state == FWP_OPEN || state == FWP_PROG)) |=> state == FWP_LOCKED;
  endproperty
  a_relock: assert property (p_relock) else $error("control write did not relock");

  property p_mass_dbg;
    @(posedge clk) disable iff (reset) (flash_cmd.mass && $past(ce)) |-> $past(dbg_mass_erase);
  endproperty
  a_mass_dbg: assert property (p_mass_dbg) else $error("mass erase not from debug");

  // user code has no way to a mass erase; the debug port has one whenever ce is high
  property p_user_no_mass;
    @(posedge clk) disable iff (reset) (ce && !dbg_mass_erase) |=> !flash_cmd.mass;
  endproperty
  a_user_no_mass: assert property (p_user_no_mass) else $error("mass without debug");

  property p_dbg_mass;
    @(posedge clk) disable iff (reset) (ce && dbg_mass_erase) |=> flash_cmd.mass;
  endproperty
  a_dbg_mass: assert property (p_dbg_mass) else $error("debug mass refused");

  property p_prog_stays;
    @(posedge clk) disable iff (reset)
      ((do_prog && !shared_wr) ##1 (ce && !ctrl_wr && !shared_wr)) |-> state == FWP_PROG;
  endproperty
  a_prog_stays: assert property (p_prog_stays) else $error("page closed after byte");

  // an accepted byte reaches the array with its page and offset
  property p_prog_open;
    @(posedge clk) disable iff (reset)
      (ce && user_wr && !ctrl_wr && (state == FWP_OPEN || state == FWP_PROG)
       && global_write_protect_option && !sect_prot[active_page[`FWP_PAGE_W-1:1]])
      |=> flash_cmd.prog && flash_cmd.page == $past(active_page)
          && flash_cmd.offs == $past(user_offs);
  endproperty
  a_prog_open: assert property (p_prog_open) else $error("byte refused");

  property p_option;
    @(posedge clk) disable iff (reset)
      (ce && !global_write_protect_option) |=> !flash_cmd.prog && !flash_cmd.erase;
  endproperty
  a_option: assert property (p_option) else $error("option bit 0 did not block");

  property p_prot_monotonic;
    @(posedge clk) disable iff (reset) ($past(sect_prot) & ~sect_prot) == 8'h00;
  endproperty
  a_prot_monotonic: assert property (p_prot_monotonic) else $error("protect cleared");

  property p_prot_reset;
    @(posedge clk) reset |=> sect_prot == 8'h00;
  endproperty
  a_prot_reset: assert property (p_prot_reset) else $error("protect not cleared");

  property p_prot_blocks;
    @(posedge clk) disable iff (reset)
      (ce && sect_prot[sector_of(active_page)]) |=> !flash_cmd.prog && !flash_cmd.erase;
  endproperty
  a_prot_blocks: assert property (p_prot_blocks) else $error("protected write");

  // an allowed erase command reaches the array in the next cycle
  property p_erase_open;
    @(posedge clk) disable iff (reset)
      (ctrl_wr && state == FWP_OPEN && reg_wdata == `FWP_CMD_ERASE
       && global_write_protect_option && !sect_prot[active_page[`FWP_PAGE_W-1:1]])
      |=> flash_cmd.erase && flash_cmd.page == $past(active_page);
  endproperty
  a_erase_open: assert property (p_erase_open) else $error("erase refused");

  // a write before or during reset must not be held against the steering
  property p_steer_past;
    @(posedge clk) disable iff (reset)
      $past(ctrl_wr && !reset) |-> sect_sel == ($past(reg_wdata) == SECT_SEL_CMD);
  endproperty
  a_steer_past: assert property (p_steer_past) else $error("shared address misrouted");

  property p_sect_other;
    @(posedge clk) disable iff (reset) (ctrl_wr && reg_wdata != SECT_SEL_CMD) |=> !sect_sel;
  endproperty
  a_sect_other: assert property (p_sect_other) else $error("protect still steered");

  // a protect write can only add bits to what is there
  property p_prot_adds;
    @(posedge clk) disable iff (reset)
      (shared_wr && sect_sel) |=> sect_prot == ($past(sect_prot) | $past(reg_wdata));
  endproperty
  a_prot_adds: assert property (p_prot_adds) else $error("protect bits not or-ed");

endmodule

// ==== tb/fwp_flash_model.sv ====
// Purpose: flash array stand-in that tallies the operations it is handed
// Assumes: erase, mass and prog arrive as one-cycle pulses
// Notes:   no storage; tallies and the last page and byte are enough to judge
`timescale 1ns/1ps
module fwp_flash_model
  import fwp_pkg::*;
(
  input  wire logic clk,
  input  fwp_cmd_s  cmd,
  output logic [7:0] n_er,
  output logic [7:0] n_pr,
  output logic [7:0] n_ms,
  output logic [3:0] l_page,
  output logic [7:0] l_data,
  output logic [8:0] l_offs
);
  // tallies start at zero; the array has no reset of its own
  initial begin
    n_er = 8'h00;
    n_pr = 8'h00;
    n_ms = 8'h00;
  end
  // the array only changes on a pulse, never on a refused request
  always @(posedge clk) begin
    if (cmd.erase) begin
      n_er   <= n_er + 8'h01;
      l_page <= cmd.page;
    end
    if (cmd.mass)
      n_ms <= n_ms + 8'h01;
    if (cmd.prog) begin
      n_pr   <= n_pr + 8'h01;
      l_page <= cmd.page;
      l_data <= cmd.data;
      l_offs <= cmd.offs;
    end
  end
endmodule

// ==== tb/flash_write_protection_lock_bench.sv ====
// Purpose: self-checking bench for the flash lock and protection logic
// Assumes: SECT_SEL_CMD left at its default, sixteen pages
// Notes:   ce is dropped once to check that nothing is taken while frozen
`timescale 1ns/1ps
`include "fwp_consts.svh"
module flash_write_protection_lock_bench;
  import fwp_pkg::*;
  logic       clk = 0, reset = 1, ce = 1, reg_wr = 0, reg_rd = 0, dbg = 0, user_wr = 0;
  logic       global_write_protect_option = 1;
  logic [1:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, user_data = 0, reg_rdata, n_er, n_pr, n_ms, l_data;
  logic [8:0] user_offs = 0, l_offs;
  logic [3:0] l_page;
  logic [7:0] e_er = 0, e_pr = 0, e_ms = 0;
  fwp_cmd_s   flash_cmd;
  int         n_mismatch = 0, n_compared = 0;
  always #5 clk = ~clk;
  fwp_lock u_fwp_lock (.clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_write_protect_option(global_write_protect_option), .dbg_mass_erase(dbg),
    .user_wr(user_wr), .user_offs(user_offs), .user_data(user_data), .flash_cmd(flash_cmd));
  fwp_flash_model u_fwp_flash_model (.clk(clk), .cmd(flash_cmd), .n_er(n_er),
    .n_pr(n_pr), .n_ms(n_ms), .l_page(l_page), .l_data(l_data), .l_offs(l_offs));
  // compare and bus tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, exp);
  endtask
  task automatic prog(input logic [8:0] o, input logic [7:0] d);
    @(posedge clk);
    user_wr   <= 1'b1;
    user_offs <= o;
    user_data <= d;
    @(posedge clk);
    user_wr <= 1'b0;
  endtask
  task automatic unlock(input logic [3:0] p);
    wr(`FWP_ADR_SHARED, {4'h0, p});
    wr(`FWP_ADR_CTRL, `FWP_KEY1);
    wr(`FWP_ADR_CTRL, `FWP_KEY2);
    wr(`FWP_ADR_SHARED, {4'h0, p});
  endtask
  task automatic mass();
    @(posedge clk);
    dbg <= 1'b1;
    @(posedge clk);
    dbg <= 1'b0;
  endtask
  // pulses land one cycle after the request, tallies one more
  task automatic cnt();
    repeat (2) @(posedge clk);
    #1 chk(n_er, e_er);
    chk(n_pr, e_pr);
    chk(n_ms, e_ms);
  endtask
  task automatic results();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(`FWP_ADR_STATUS, 8'h1f, 8'h10);
    rd(2'h3, 8'hff, 8'h00);
    prog(9'h000, 8'h5a);
    cnt();
    unlock(4'h3);
    rd(`FWP_ADR_STATUS, 8'h01, 8'h01);
    prog(9'h000, 8'ha1);
    prog(9'h1ff, 8'hb2);
    e_pr = e_pr + 8'h02;
    cnt();
    chk(l_data, 8'hb2);
    chk({4'h0, l_page}, 8'h03);
    chk(l_offs[7:0], 8'hff);
    chk({7'h00, l_offs[8]}, 8'h01);
    rd(`FWP_ADR_STATUS, 8'h03, 8'h03);
    wr(`FWP_ADR_CTRL, 8'h00);
    prog(9'h001, 8'hc3);
    cnt();
    rd(`FWP_ADR_CTRL, 8'hff, 8'h00);
    wr(`FWP_ADR_SHARED, 8'h02);
    wr(`FWP_ADR_CTRL, `FWP_KEY1);
    wr(`FWP_ADR_CTRL, `FWP_KEY2);
    wr(`FWP_ADR_SHARED, 8'h05);
    rd(`FWP_ADR_STATUS, 8'h01, 8'h00);
    // second key written in place of the first drops the sequence
    wr(`FWP_ADR_SHARED, 8'h02);
    wr(`FWP_ADR_CTRL, `FWP_KEY2);
    wr(`FWP_ADR_CTRL, `FWP_KEY2);
    wr(`FWP_ADR_SHARED, 8'h02);
    rd(`FWP_ADR_STATUS, 8'h01, 8'h00);
    unlock(4'h4);
    wr(`FWP_ADR_CTRL, `FWP_CMD_ERASE);
    e_er++;
    cnt();
    chk({4'h0, l_page}, 8'h04);
    unlock(4'h6);
    wr(`FWP_ADR_CTRL, 8'h11);
    prog(9'h002, 8'h01);
    cnt();
    // protect sector 2, then try to clear it
    wr(`FWP_ADR_CTRL, `FWP_CMD_SECTSEL);
    wr(`FWP_ADR_SHARED, 8'h04);
    rd(`FWP_ADR_STATUS, 8'h04, 8'h04);
    wr(`FWP_ADR_CTRL, `FWP_CMD_SECTSEL);
    wr(`FWP_ADR_SHARED, 8'h00);
    rd(`FWP_ADR_SHARED, 8'hff, 8'h04);
    wr(`FWP_ADR_CTRL, 8'h00);
    rd(`FWP_ADR_SHARED, 8'hff, 8'h06);
    unlock(4'h5);
    prog(9'h003, 8'h77);
    wr(`FWP_ADR_CTRL, `FWP_CMD_ERASE);
    cnt();
    unlock(4'h4);
    wr(`FWP_ADR_CTRL, `FWP_CMD_ERASE);
    cnt();
    unlock(4'h3);
    wr(`FWP_ADR_CTRL, `FWP_CMD_ERASE);
    e_er++;
    cnt();
    // option bit low blocks user operations only
    @(posedge clk);
    global_write_protect_option <= 1'b0;
    unlock(4'h1);
    prog(9'h004, 8'h33);
    wr(`FWP_ADR_CTRL, `FWP_CMD_ERASE);
    cnt();
    mass();
    e_ms++;
    cnt();
    @(posedge clk);
    global_write_protect_option <= 1'b1;
    mass();
    e_ms++;
    cnt();
    unlock(4'h1);
    prog(9'h005, 8'h44);
    e_pr++;
    cnt();
    // frozen clock enable: neither the byte nor the relocking write is taken
    @(posedge clk);
    ce <= 1'b0;
    prog(9'h006, 8'h55);
    wr(`FWP_ADR_CTRL, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    cnt();
    rd(`FWP_ADR_STATUS, 8'h01, 8'h01);
    // reset in mid-run drops lock and sector protection
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(`FWP_ADR_STATUS, 8'h01, 8'h00);
    unlock(4'h4);
    wr(`FWP_ADR_CTRL, `FWP_CMD_ERASE);
    e_er++;
    cnt();
    results();
  end
endmodule
